// ==== src/sdc_pkg.sv ====
// Package: register map, fields, reset values and timing constants
package sdc_pkg;
  localparam logic [1:0] ADDR_CTRL_A = 2'h0;
  localparam logic [1:0] ADDR_CTRL_B = 2'h1;
  localparam logic [1:0] ADDR_FRAME_RATE = 2'h2;
  localparam logic [1:0] ADDR_ASYNC_STAT = 2'h3;
  // Control A fields
  localparam int A_ON = 7;
  localparam int A_WAVE = 6;
  localparam int A_FLAG = 4;
  localparam int A_IRQ_EN = 3;
  localparam int A_BLANK = 0;
  localparam logic [7:0] A_WMASK = 8'hC9;
  // Control B fields
  localparam int B_CLK_SEL = 7;
  localparam int B_HALF_BIAS = 6;
  localparam int B_DUTY_LO = 4;
  localparam logic [7:0] B_WMASK = 8'hF7;
  // Frame rate fields
  localparam int F_PS_LO = 4;
  localparam logic [7:0] F_WMASK = 8'h77;
  localparam logic [7:0] A_RESET = 8'h00;
  localparam logic [7:0] B_RESET = 8'h00;
  localparam logic [7:0] F_RESET = 8'h00;
  // Duty codes
  localparam logic [1:0] DUTY_STATIC = 2'h0;
  localparam logic [1:0] DUTY_THIRD = 2'h2;
  // Frame length factor
  localparam logic [3:0] K_NORMAL = 4'h8;
  localparam logic [3:0] K_THIRD = 4'h6;
  localparam int PS_W = 12;
  localparam int SEG_N = 25;
  localparam int COM_N = 4;
  typedef enum logic [1:0] {SDC_OFF, SDC_RUN, SDC_BLANKED} sdc_state_e;
endpackage

// ==== src/sdc_clk_mux.sv ====
// Source clock tick selection
`timescale 1ns/100ps
module sdc_clk_mux
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sel_async,
  input wire logic ext_clk_en,
  input wire logic osc_tick,
  input wire logic ext_tick,
  output logic tick
);
  import sdc_pkg::*;
  typedef struct packed {logic tick;} sdc_mux_s;
  sdc_mux_s s_q;
  sdc_mux_s s_d;
  always_comb begin
    s_d = s_q;
    if (!sel_async) begin
      s_d.tick = 1'b1;
    end else begin
      s_d.tick = ext_clk_en ? ext_tick : osc_tick;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule

// ==== src/sdc_rate_div.sv ====
// Prescaler tap and extra divider producing prescaled ticks
`timescale 1ns/100ps
module sdc_rate_div
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [2:0] tap_sel,
  input wire logic [2:0] div_sel,
  output logic ps_tick
);
  import sdc_pkg::*;
  typedef struct packed {
    logic [PS_W-1:0] pre;
    logic [2:0] div;
    logic ps_tick;
  } sdc_div_s;
  sdc_div_s s_q;
  sdc_div_s s_d;
  logic [PS_W-1:0] tap_last;
  always_comb begin
    case (tap_sel)
      3'h0: tap_last = 12'h00F;
      3'h1: tap_last = 12'h03F;
      3'h2: tap_last = 12'h07F;
      3'h3: tap_last = 12'h0FF;
      3'h4: tap_last = 12'h1FF;
      3'h5: tap_last = 12'h3FF;
      3'h6: tap_last = 12'h7FF;
      default: tap_last = 12'hFFF;
    endcase
  end
  always_comb begin
    s_d = s_q;
    s_d.ps_tick = 1'b0;
    if (!run) begin
      s_d.pre = '0;
      s_d.div = '0;
    end else if (src_tick) begin
      if (s_q.pre >= tap_last) begin
        s_d.pre = '0;
        if (s_q.div >= div_sel) begin
          s_d.div = '0;
          s_d.ps_tick = 1'b1;
        end else begin
          s_d.div = s_q.div + 3'h1;
        end
      end else begin
        s_d.pre = s_q.pre + 12'h001;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign ps_tick = s_q.ps_tick;
endmodule

// ==== src/sdc_top.sv ====
// Segment display controller: registers, frame timing, pin ownership
// Notes on behaviour
// - Enable bit on; clearing it stops immediately
// - Disabled controller returns pins to port
// - Waveform bit applied at next frame start
// - Flag set at frame start with latch
// - Flag cleared by vector or written one
// - Interrupt when flag, enable, global enable
// - Low-toggle wave: flag every second frame
// - Reserved bits read zero, ignore writes
// - Blank after frame; pins to ground
// - Clock select: system or async source
// - Bias bit: one-third or one-half
// - Duty field selects used commons
// - Unused commons released to port
// - Segment mask selects driven segment pins
// - Prescaler tap divides by 16..4096
// - Tap output through extra divider
// - Divider ratio is code plus one
// - Frame lasts K times prescaled periods
// - Data, blank, wave, contrast latched per frame, every second frame with low-toggle wave
`timescale 1ns/100ps
module sdc_top
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic global_irq_en,
  input wire logic irq_vector_ack,
  input wire logic osc_tick,
  input wire logic ext_tick,
  input wire logic ext_clk_input_en,
  input wire logic [3:0] contrast_setting,
  input wire logic [sdc_pkg::SEG_N-1:0] display_memory,
  output logic frame_irq,
  output logic [sdc_pkg::SEG_N-1:0] seg_drive_en,
  output logic [sdc_pkg::COM_N-1:0] com_drive_en,
  output logic pins_grounded,
  output logic wave_low_toggle,
  output logic half_bias,
  output logic static_bias,
  output logic [1:0] duty_active,
  output logic [3:0] contrast_active,
  output logic [sdc_pkg::SEG_N-1:0] frame_data,
  output logic frame_start
);
  import sdc_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] rate;
    logic [7:0] rdata;
    sdc_state_e st;
    logic [3:0] step;
    logic odd_frame;
    logic wave_lat;
    logic blank_lat;
    logic [3:0] contrast_lat;
    logic [SEG_N-1:0] data_lat;
    logic irq;
    logic [SEG_N-1:0] seg_en;
    logic [COM_N-1:0] com_en;
    logic grounded;
    logic half_bias;
    logic static_bias;
    logic frame_start;
  } sdc_state_s;
  sdc_state_s s_q;
  sdc_state_s s_d;
  logic src_tick;
  logic ps_tick;
  logic on;
  logic [3:0] k_last;
  logic boundary;
  logic latch_now;
  logic [SEG_N-1:0] seg_mask;
  logic [COM_N-1:0] com_mask;
  logic [1:0] duty;

  assign on = s_q.ctrl_a[A_ON];
  assign duty = s_q.ctrl_b[B_DUTY_LO+1:B_DUTY_LO];

  sdc_clk_mux u_mux (
    .clock(clock),
    .rst_n(rst_n),
    .sel_async(s_q.ctrl_b[B_CLK_SEL]),
    .ext_clk_en(ext_clk_input_en),
    .osc_tick(osc_tick),
    .ext_tick(ext_tick),
    .tick(src_tick)
  );

  sdc_rate_div u_div (
    .clock(clock),
    .rst_n(rst_n),
    .run(on),
    .src_tick(src_tick),
    .tap_sel(s_q.rate[F_PS_LO+2:F_PS_LO]),
    .div_sel(s_q.rate[2:0]),
    .ps_tick(ps_tick)
  );

  // Frame length in prescaled ticks
  always_comb begin
    k_last = (duty == DUTY_THIRD) ? K_THIRD - 4'h1 : K_NORMAL - 4'h1;
    boundary = on && ps_tick && (s_q.step >= k_last);
    // Low-toggle wave latches only every second frame
    latch_now = boundary && (!s_q.wave_lat || s_q.odd_frame);
  end

  // Segment pins owned per mask code
  always_comb begin
    case (s_q.ctrl_b[2:0])
      3'h0: seg_mask = 25'h0001FFF;
      3'h1: seg_mask = 25'h0007FFF;
      3'h2: seg_mask = 25'h001FFFF;
      3'h3: seg_mask = 25'h007FFFF;
      3'h4: seg_mask = 25'h01FFFFF;
      3'h5: seg_mask = 25'h07FFFFF;
      3'h6: seg_mask = 25'h0FFFFFF;
      default: seg_mask = 25'h1FFFFFF;
    endcase
    case (duty)
      2'h0: com_mask = 4'h1;
      2'h1: com_mask = 4'h3;
      2'h2: com_mask = 4'h7;
      default: com_mask = 4'hF;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.frame_start = 1'b0;
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL_A: begin
          s_d.ctrl_a = reg_wdata & A_WMASK;
          s_d.ctrl_a[A_FLAG] = s_q.ctrl_a[A_FLAG] && !reg_wdata[A_FLAG];
        end
        ADDR_CTRL_B: begin
          s_d.ctrl_b = reg_wdata & B_WMASK;
        end
        ADDR_FRAME_RATE: begin
          s_d.rate = reg_wdata & F_WMASK;
        end
        default: begin
        end
      endcase
    end
    if (irq_vector_ack) begin
      s_d.ctrl_a[A_FLAG] = 1'b0;
    end
    // Frame sequencing
    if (!s_d.ctrl_a[A_ON]) begin
      s_d.st = SDC_OFF;
      s_d.step = '0;
      s_d.odd_frame = 1'b0;
    end else begin
      case (s_q.st)
        SDC_OFF: begin
          s_d.st = SDC_RUN;
          s_d.step = '0;
          s_d.wave_lat = s_d.ctrl_a[A_WAVE];
          s_d.blank_lat = 1'b0;
        end
        SDC_RUN, SDC_BLANKED: begin
          if (boundary) begin
            s_d.step = '0;
            s_d.odd_frame = !s_q.odd_frame;
            if (latch_now) begin
              s_d.ctrl_a[A_FLAG] = 1'b1;
              s_d.frame_start = 1'b1;
              s_d.odd_frame = 1'b0;
              s_d.wave_lat = s_q.ctrl_a[A_WAVE];
              s_d.blank_lat = s_q.ctrl_a[A_BLANK];
              s_d.contrast_lat = contrast_setting;
              s_d.data_lat = display_memory;
              s_d.st = s_q.ctrl_a[A_BLANK] ? SDC_BLANKED : SDC_RUN;
            end
          end else if (ps_tick) begin
            s_d.step = s_q.step + 4'h1;
          end
        end
        default: s_d.st = SDC_OFF;
      endcase
    end
    // Read port
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL_A: s_d.rdata = s_q.ctrl_a;
        ADDR_CTRL_B: s_d.rdata = s_q.ctrl_b;
        ADDR_FRAME_RATE: s_d.rdata = s_q.rate;
        ADDR_ASYNC_STAT: s_d.rdata = {6'h00, s_q.st == SDC_BLANKED, s_q.odd_frame};
        default: s_d.rdata = 8'h00;
      endcase
    end
    s_d.irq = s_d.ctrl_a[A_FLAG] && s_d.ctrl_a[A_IRQ_EN] && global_irq_en;
    // Pin ownership
    if (s_d.ctrl_a[A_ON]) begin
      s_d.seg_en = seg_mask;
      s_d.com_en = com_mask;
    end else begin
      s_d.seg_en = '0;
      s_d.com_en = '0;
    end
    s_d.grounded = s_d.ctrl_a[A_ON] && (s_d.st == SDC_BLANKED);
    s_d.half_bias = s_q.ctrl_b[B_HALF_BIAS] && (duty != DUTY_STATIC);
    s_d.static_bias = (duty == DUTY_STATIC);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl_a <= A_RESET;
      s_q.ctrl_b <= B_RESET;
      s_q.rate <= F_RESET;
      s_q.st <= SDC_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign frame_irq = s_q.irq;
  assign seg_drive_en = s_q.seg_en;
  assign com_drive_en = s_q.com_en;
  assign pins_grounded = s_q.grounded;
  assign wave_low_toggle = s_q.wave_lat;
  assign half_bias = s_q.half_bias;
  assign static_bias = s_q.static_bias;
  assign duty_active = duty;
  assign contrast_active = s_q.contrast_lat;
  assign frame_data = s_q.data_lat;
  assign frame_start = s_q.frame_start;
endmodule

// ==== testbench/sdc_glass.sv ====
// Passive display glass model on the drive pins
`timescale 1ns/100ps
module sdc_glass
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic [sdc_pkg::COM_N-1:0] com_drive_en,
  input wire logic pins_grounded,
  output logic discharged = 1'b1
);
  import sdc_pkg::*;
  // Charge builds while driven, drains when grounded
  always @(posedge clock) begin
    if (pins_grounded)
      discharged <= 1'b1;
    else if (com_drive_en != 4'h0)
      discharged <= 1'b0;
  end
endmodule

// ==== testbench/sdc_top_chk.sv ====
// Port checker for the display controller
`timescale 1ns/100ps
module sdc_top_chk
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic global_irq_en,
  input wire logic frame_irq,
  input wire logic [sdc_pkg::SEG_N-1:0] seg_drive_en,
  input wire logic [sdc_pkg::COM_N-1:0] com_drive_en,
  input wire logic pins_grounded,
  input wire logic wave_low_toggle,
  input wire logic half_bias,
  input wire logic static_bias,
  input wire logic [1:0] duty_active,
  input wire logic frame_start
);
  import sdc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_off;
    reg_wr && reg_addr == ADDR_CTRL_A && !reg_wdata[A_ON] |=> {com_drive_en, seg_drive_en} == '0;
  endproperty
  a_off: assert property (p_off) else $error("pins kept after disable");
  property p_rsv;
    $past(reg_rd) |-> (reg_rdata & ~(($past(reg_addr) == ADDR_CTRL_A) ? 8'hD9 :
      ($past(reg_addr) == ADDR_CTRL_B) ? B_WMASK :
      ($past(reg_addr) == ADDR_FRAME_RATE) ? F_WMASK : 8'h03)) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read one");
  property p_irq;
    !global_irq_en [*2] |-> !frame_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without global enable");
  property p_com;
    com_drive_en != 4'h0 && $stable(duty_active) |->
      com_drive_en == 4'((5'h2 << duty_active) - 5'h1);
  endproperty
  a_com: assert property (p_com) else $error("commons mismatch duty");
  property p_seg;
    seg_drive_en != '0 |-> seg_drive_en[12:0] == 13'h1FFF;
  endproperty
  a_seg: assert property (p_seg) else $error("low segments not driven");
  property p_bias;
    $stable(duty_active) && $past(rst_n) |-> static_bias == (duty_active == DUTY_STATIC);
  endproperty
  a_bias: assert property (p_bias) else $error("static bias wrong");
  property p_hbias;
    $stable(duty_active) && duty_active == DUTY_STATIC |-> !half_bias;
  endproperty
  a_hbias: assert property (p_hbias) else $error("half bias in static duty");
  property p_fs;
    frame_start |=> !frame_start [*8];
  endproperty
  a_fs: assert property (p_fs) else $error("frame start too close");
  property p_blank;
    $rose(pins_grounded) |-> frame_start || $past(frame_start);
  endproperty
  a_blank: assert property (p_blank) else $error("blank off frame edge");
  property p_wave;
    $changed(wave_low_toggle) && $past(com_drive_en) != 4'h0 |-> frame_start || $past(frame_start);
  endproperty
  a_wave: assert property (p_wave) else $error("wave change mid frame");
endmodule
bind sdc_top sdc_top_chk u_chk (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .global_irq_en, .frame_irq, .seg_drive_en, .com_drive_en, .pins_grounded,
  .wave_low_toggle, .half_bias, .static_bias, .duty_active, .frame_start);

// ==== testbench/sdc_top_tb.sv ====
// Testbench for the display controller
`timescale 1ns/100ps
module sdc_top_tb;
  import sdc_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
  logic global_irq_en = 1'b0, irq_vector_ack = 1'b0, osc_tick = 1'b0, ext_tick = 1'b0;
  logic ext_clk_input_en = 1'b0, frame_irq, pins_grounded, wave_low_toggle, half_bias;
  logic static_bias, frame_start, discharged;
  logic [1:0] reg_addr = 2'h0, duty_active;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] contrast_setting = 4'h0, contrast_active;
  logic [SEG_N-1:0] display_memory = '0, seg_drive_en, frame_data;
  logic [COM_N-1:0] com_drive_en;
  logic [7:0] rq[$];
  logic [1:0] tick_cnt = 2'h0;
  logic [7:0] bt[6] = '{8'h37, 8'h27, 8'h37, 8'h17, 8'hB7, 8'hB7};
  logic [7:0] ft[6] = '{8'h00, 8'h00, 8'h01, 8'h10, 8'h00, 8'h00};
  logic [3:0] comm[4] = '{4'h1, 4'h3, 4'h7, 4'hF};
  int pt[6] = '{128, 96, 256, 512, 256, 512};
  int segn[8] = '{13, 15, 17, 19, 21, 23, 24, 25};
  int n_fail = 0, n_compared = 0, t;
  always #12.5 clock = ~clock;
  sdc_top dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .global_irq_en, .irq_vector_ack, .osc_tick, .ext_tick, .ext_clk_input_en,
    .contrast_setting, .display_memory, .frame_irq, .seg_drive_en, .com_drive_en,
    .pins_grounded, .wave_low_toggle, .half_bias, .static_bias, .duty_active,
    .contrast_active, .frame_data, .frame_start);
  sdc_glass glass (.clock, .com_drive_en, .pins_grounded, .discharged);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_fs(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (frame_start !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      n_fail++;
      final_report();
    end
  endtask
  // Read data checked in the cycle after the strobe
  always @(posedge clock) begin
    osc_tick <= ~osc_tick;
    tick_cnt <= tick_cnt + 2'h1;
    ext_tick <= (tick_cnt == 2'h3);
    rd_q <= reg_rd;
    if (rd_q)
      chk(reg_rdata, rq.pop_front());
  end
  initial begin
    logic [7:0] v;
    logic [SEG_N-1:0] m;
    void'($urandom(522));
    repeat (10) @(posedge clock);
    display_memory <= SEG_N'($urandom);
    contrast_setting <= 4'($urandom);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(ADDR_CTRL_A, A_RESET);
    rd(ADDR_CTRL_B, B_RESET);
    rd(ADDR_FRAME_RATE, F_RESET);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(ADDR_CTRL_B, v);
      rd(ADDR_CTRL_B, v & B_WMASK);
      wr(ADDR_FRAME_RATE, v);
      rd(ADDR_FRAME_RATE, v & F_WMASK);
      wr(ADDR_CTRL_A, v & 8'h6F);
      rd(ADDR_CTRL_A, v & 8'h49);
    end
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL_B, {1'b0, 1'(i / 4), 2'(i), 1'b0, 3'(i)});
      wr(ADDR_CTRL_A, 8'h80);
      chk(half_bias, i >= 4 && i % 4 != 0);
      chk(com_drive_en, comm[i % 4]);
      chk(seg_drive_en, (32'h1 << segn[i]) - 32'h1);
      chk(static_bias, i % 4 == 0);
      wr(ADDR_CTRL_A, 8'h00);
      chk({com_drive_en, seg_drive_en}, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      ext_clk_input_en <= (i == 5);
      wr(ADDR_CTRL_B, bt[i]);
      wr(ADDR_FRAME_RATE, ft[i]);
      wr(ADDR_CTRL_A, 8'h80);
      wait_fs(t);
      wait_fs(t);
      chk(t, pt[i]);
      wr(ADDR_CTRL_A, 8'h00);
    end
    wr(ADDR_CTRL_B, 8'h37);
    wr(ADDR_CTRL_A, 8'h88);
    global_irq_en <= 1'b1;
    wait_fs(t);
    chk(frame_data, display_memory);
    chk(contrast_active, contrast_setting);
    rd(ADDR_CTRL_A, 8'h98);
    chk(frame_irq, 1'b1);
    m = display_memory;
    display_memory <= ~m;
    irq_vector_ack <= 1'b1;
    @(posedge clock);
    irq_vector_ack <= 1'b0;
    rd(ADDR_CTRL_A, 8'h88);
    chk(frame_irq, 1'b0);
    chk(frame_data, m);
    wait_fs(t);
    chk(frame_data, display_memory);
    wr(ADDR_CTRL_A, 8'h88);
    rd(ADDR_CTRL_A, 8'h98);
    wr(ADDR_CTRL_A, 8'hD0);
    rd(ADDR_CTRL_A, 8'hC0);
    repeat (3) wait_fs(t);
    chk(t, 256);
    chk(wave_low_toggle, 1'b1);
    wr(ADDR_CTRL_A, 8'h91);
    wait_fs(t);
    repeat (2) @(posedge clock);
    chk(pins_grounded, 1'b1);
    chk(discharged, 1'b1);
    wr(ADDR_CTRL_A, 8'h00);
    chk({com_drive_en, seg_drive_en}, 32'h0);
    final_report();
  end
endmodule
